// File: logic/dor_pkg.sv
// Purpose: constants for the digital output routing block
// Assumes: AHB-Lite register access, 32-bit words
// Notes: register offsets are byte addresses
package dor_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] DOR_OFS_ROUTE_EN = 8'h00;
  localparam logic [7:0] DOR_OFS_POLARITY = 8'h04;
  localparam logic [7:0] DOR_OFS_MAN_SEL = 8'h08;
  localparam logic [7:0] DOR_OFS_MAN_VAL = 8'h0c;
  localparam logic [7:0] DOR_OFS_OUT_WORD = 8'h10;
  localparam logic [7:0] DOR_OFS_PIN_STATE = 8'h14;
  localparam logic [7:0] DOR_OFS_BRAKE_PER = 8'h18;
  localparam logic [7:0] DOR_OFS_BRAKE_ON = 8'h1c;
  localparam logic [7:0] DOR_OFS_ENC_CNT = 8'h20;
  localparam logic [7:0] DOR_OFS_POS_CNT = 8'h24;
  localparam logic [7:0] DOR_OFS_ROUTE0 = 8'h40;
  localparam logic [7:0] DOR_ROUTE_STRIDE = 8'h04;
  // ----------------------------------------------------------------
  // field layout of a routing entry
  // ----------------------------------------------------------------
  localparam int DOR_SRC_LSB = 8;
  localparam int DOR_INV_BIT = 7;
  localparam int DOR_IDX_LSB = 0;
  localparam int DOR_IDX_W = 5;
  localparam logic [15:0] DOR_ROUTE_RST = 16'h0100;
  // ----------------------------------------------------------------
  // source codes
  // ----------------------------------------------------------------
  localparam logic [7:0] DOR_SRC_ONE = 8'h00;
  localparam logic [7:0] DOR_SRC_ZERO = 8'h01;
  localparam logic [7:0] DOR_SRC_ENC0 = 8'h02;
  localparam logic [7:0] DOR_SRC_ENC6 = 8'h08;
  localparam logic [7:0] DOR_SRC_POS0 = 8'h09;
  localparam logic [7:0] DOR_SRC_POS6 = 8'h0f;
  localparam logic [7:0] DOR_SRC_BRK = 8'h10;
  localparam logic [7:0] DOR_SRC_BRK_N = 8'h11;
  // ----------------------------------------------------------------
  // toggle-rate limits
  // ----------------------------------------------------------------
  localparam int DOR_CLK_HZ = 50000000;
  localparam int DOR_PWM_MAX_HZ = 2000;
  localparam int DOR_OUT_MAX_HZ = 500;
  localparam int DOR_PWM_GAP = DOR_CLK_HZ / (2 * DOR_PWM_MAX_HZ);
  localparam int DOR_OUT_GAP = DOR_CLK_HZ / (2 * DOR_OUT_MAX_HZ);
  localparam logic [15:0] DOR_BRAKE_PER_RST = 16'h0064;
  localparam logic [15:0] DOR_BRAKE_ON_RST = 16'h0032;
endpackage

// File: logic/dor_output_lane.sv
// Purpose: one routed output: source select, gating and rate limit
// Assumes: pulse trains arrive as one-cycle toggle requests
// Notes: the lane holds its level between allowed toggles
module dor_output_lane #(
  parameter int GAP = 25000
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // configuration
  input wire logic [15:0] route,
  input wire logic [31:0] out_word,
  // sources
  input wire logic [6:0] enc_tick,
  input wire logic [6:0] pos_tick,
  input wire logic brake_pwm,
  // result
  output logic lane_out
);
  import dor_pkg::*;

  logic [7:0] src;
  logic gate;
  logic want_toggle;
  logic want_level;
  logic level_mode;
  logic [2:0] div_sel;
  logic [24:0] gap_cnt;
  logic [24:0] next_gap_cnt;
  logic next_lane_out;
  logic pend;
  logic next_pend;

  // gating bit, optionally inverted
  always_comb
  begin
    src = route[15:DOR_SRC_LSB];
    gate = out_word[route[DOR_IDX_LSB +: DOR_IDX_W]] ^ route[DOR_INV_BIT];
    div_sel = 3'h0;
    want_toggle = 1'b0;
    level_mode = 1'b1;
    want_level = 1'b0;
    if (!gate)
      want_level = 1'b0;
    else if (src == DOR_SRC_ONE)
      want_level = 1'b1;
    else if (src == DOR_SRC_ZERO)
      want_level = 1'b0;
    else if (src >= DOR_SRC_ENC0 && src <= DOR_SRC_ENC6)
    begin
      div_sel = 3'(src - DOR_SRC_ENC0);
      level_mode = 1'b0;
      want_toggle = enc_tick[div_sel];
    end
    else if (src >= DOR_SRC_POS0 && src <= DOR_SRC_POS6)
    begin
      div_sel = 3'(src - DOR_SRC_POS0);
      level_mode = 1'b0;
      want_toggle = pos_tick[div_sel];
    end
    else if (src == DOR_SRC_BRK)
      want_level = brake_pwm;
    else if (src == DOR_SRC_BRK_N)
      want_level = ~brake_pwm;
    else
      want_level = 1'b0;
  end

  // rate limiter: a change waits until the gap since the last one has passed; a closed gate forces level mode at zero, which also waits for the gap
  always_comb
  begin
    next_gap_cnt = (gap_cnt != 25'h0) ? gap_cnt - 25'h1 : gap_cnt;
    next_lane_out = lane_out;
    next_pend = pend;
    if (level_mode)
      next_pend = 1'b0;
    else if (want_toggle)
      next_pend = 1'b1;
    if (!gate && !level_mode)
      next_lane_out = 1'b0;
    if (gap_cnt == 25'h0)
    begin
      if (level_mode && want_level != lane_out)
      begin
        next_lane_out = want_level;
        next_gap_cnt = 25'(GAP - 1);
      end
      else if (!level_mode && gate && (pend || want_toggle))
      begin
        next_lane_out = ~lane_out;
        next_pend = 1'b0;
        next_gap_cnt = 25'(GAP - 1);
      end
    end
  end

  // state registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gap_cnt <= 25'h0;
      lane_out <= 1'b0;
      pend <= 1'b0;
    end
    else
    begin
      gap_cnt <= next_gap_cnt;
      lane_out <= next_lane_out;
      pend <= next_pend;
    end
  end
endmodule

// File: logic/dor_top.sv
// Purpose: digital output routing crossbar with AHB-Lite registers
// Assumes: encoder and position counts are synchronous to hclk
// Notes: lane 0 is the software pwm output, lane n is output n-1
// Summary of operation
// - routing acts only while the routing enable register holds one
// - while routing, polarity, manual select and value are ignored
// - route entry is 16 bits: high byte source, low byte gate
// - entry zero feeds pwm output, entry n feeds output n-1
// - bit 7 clear means gate one enables; set means zero enables
// - low bits of the low byte index the output word bit
// - source 00 drives constant one, 01 constant zero
// - sources 02..08 route encoder pulses divided by 1..64
// - sources 09..0f route position pulses divided by 1..64
// - source 10 routes brake pwm, 11 its inverse
// - each unit count change gives one pulse at divider one
// - while routing, pwm output toggles at most 2 kHz, others at 500 Hz; the normal path has no rate limit
module dor_top #(
  parameter int NUM_OUT = 2,
  parameter int PWM_GAP = 12500,
  parameter int OUT_GAP = 50000
) (
  // ahb-lite slave
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // motion counts
  input wire logic [31:0] enc_count,
  input wire logic [31:0] pos_count,
  // outputs
  output logic pwm_out,
  output logic [NUM_OUT-1:0] dig_out
);
  import dor_pkg::*;

  localparam int LANES = NUM_OUT + 1;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic route_en;
  logic [31:0] polarity;
  logic [31:0] man_sel;
  logic [31:0] man_val;
  logic [31:0] digital_output_word;
  logic [15:0] brake_per;
  logic [15:0] brake_on;
  logic [15:0] route [LANES];
  logic [31:0] pin_state;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic next_wr_pend;
  logic [7:0] next_wr_addr;
  logic [31:0] next_hrdata;
  logic addr_ok;
  logic next_route_en;
  logic [31:0] next_polarity;
  logic [31:0] next_man_sel;
  logic [31:0] next_man_val;
  logic [31:0] next_digital_output_word;
  logic [15:0] next_brake_per;
  logic [15:0] next_brake_on;
  logic [15:0] next_route [LANES];

  // address phase capture; every access is zero wait
  always_comb
  begin
    addr_ok = hsel && hready && htrans[1];
    next_wr_pend = addr_ok && hwrite;
    next_wr_addr = addr_ok ? haddr[7:0] : wr_addr;
    next_hrdata = 32'h0;
    if (addr_ok && !hwrite)
    begin
      case (haddr[7:0])
        DOR_OFS_ROUTE_EN: next_hrdata = {31'h0, route_en};
        DOR_OFS_POLARITY: next_hrdata = polarity;
        DOR_OFS_MAN_SEL: next_hrdata = man_sel;
        DOR_OFS_MAN_VAL: next_hrdata = man_val;
        DOR_OFS_OUT_WORD: next_hrdata = digital_output_word;
        DOR_OFS_PIN_STATE: next_hrdata = pin_state;
        DOR_OFS_BRAKE_PER: next_hrdata = {16'h0, brake_per};
        DOR_OFS_BRAKE_ON: next_hrdata = {16'h0, brake_on};
        DOR_OFS_ENC_CNT: next_hrdata = enc_count;
        DOR_OFS_POS_CNT: next_hrdata = pos_count;
        default:
        begin
          for (int i = 0; i < LANES; i++)
            if (haddr[7:0] == 8'(DOR_OFS_ROUTE0 + i * DOR_ROUTE_STRIDE))
              next_hrdata = {16'h0, route[i]};
        end
      endcase
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // bus phase registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h0;
      hrdata <= 32'h0;
    end
    else
    begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
    end
  end

  // register writes in the data phase; unmapped writes are dropped
  always_comb
  begin
    next_route_en = route_en;
    next_polarity = polarity;
    next_man_sel = man_sel;
    next_man_val = man_val;
    next_digital_output_word = digital_output_word;
    next_brake_per = brake_per;
    next_brake_on = brake_on;
    for (int i = 0; i < LANES; i++)
      next_route[i] = route[i];
    if (wr_pend)
    begin
      case (wr_addr)
        DOR_OFS_ROUTE_EN: next_route_en = (hwdata == 32'h1);
        DOR_OFS_POLARITY: next_polarity = hwdata;
        DOR_OFS_MAN_SEL: next_man_sel = hwdata;
        DOR_OFS_MAN_VAL: next_man_val = hwdata;
        DOR_OFS_OUT_WORD: next_digital_output_word = hwdata;
        DOR_OFS_BRAKE_PER: next_brake_per = hwdata[15:0];
        DOR_OFS_BRAKE_ON: next_brake_on = hwdata[15:0];
        default:
        begin
          for (int i = 0; i < LANES; i++)
            if (wr_addr == 8'(DOR_OFS_ROUTE0 + i * DOR_ROUTE_STRIDE))
              next_route[i] = hwdata[15:0];
        end
      endcase
    end
  end

  // register file flops; routes wake up as constant zero so pins stay quiet
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      route_en <= 1'b0;
      polarity <= 32'h0;
      man_sel <= 32'h0;
      man_val <= 32'h0;
      digital_output_word <= 32'h0;
      brake_per <= DOR_BRAKE_PER_RST;
      brake_on <= DOR_BRAKE_ON_RST;
      for (int i = 0; i < LANES; i++)
        route[i] <= DOR_ROUTE_RST;
    end
    else
    begin
      route_en <= next_route_en;
      polarity <= next_polarity;
      man_sel <= next_man_sel;
      man_val <= next_man_val;
      digital_output_word <= next_digital_output_word;
      brake_per <= next_brake_per;
      brake_on <= next_brake_on;
      for (int i = 0; i < LANES; i++)
        route[i] <= next_route[i];
    end
  end

  // ----------------------------------------------------------------
  // pulse trains from the counts
  // ----------------------------------------------------------------
  logic [31:0] enc_prev;
  logic [31:0] pos_prev;
  logic [6:0] enc_tick;
  logic [6:0] pos_tick;
  logic [5:0] enc_acc;
  logic [5:0] pos_acc;
  logic [5:0] next_enc_acc;
  logic [5:0] next_pos_acc;
  logic enc_step;
  logic pos_step;

  // one step per unit change; a jump of several counts still gives one,
  // since the lane output cannot toggle faster than its rate limit anyway
  always_comb
  begin
    enc_step = (enc_count != enc_prev);
    pos_step = (pos_count != pos_prev);
    next_enc_acc = enc_step ? enc_acc + 6'h1 : enc_acc;
    next_pos_acc = pos_step ? pos_acc + 6'h1 : pos_acc;
  end

  // divider taps: tap k fires when the low k bits roll over
  genvar k;
  generate
    for (k = 0; k < 7; k++)
    begin : g_tap
      if (k == 0)
      begin : g_base
        assign enc_tick[k] = enc_step;
        assign pos_tick[k] = pos_step;
      end
      else
      begin : g_div
        assign enc_tick[k] = enc_step && (enc_acc[k-1:0] == {k{1'b1}});
        assign pos_tick[k] = pos_step && (pos_acc[k-1:0] == {k{1'b1}});
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      enc_prev <= 32'h0;
      pos_prev <= 32'h0;
      enc_acc <= 6'h0;
      pos_acc <= 6'h0;
    end
    else
    begin
      enc_prev <= enc_count;
      pos_prev <= pos_count;
      enc_acc <= next_enc_acc;
      pos_acc <= next_pos_acc;
    end
  end

  // ----------------------------------------------------------------
  // brake pwm generator
  // ----------------------------------------------------------------
  logic [15:0] brk_cnt;
  logic [15:0] next_brk_cnt;
  logic brake_pwm;

  // high for brake_on cycles of every brake_per cycles
  always_comb
  begin
    next_brk_cnt = (brk_cnt + 16'h1 >= brake_per) ? 16'h0 : brk_cnt + 16'h1;
    brake_pwm = (brk_cnt < brake_on);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      brk_cnt <= 16'h0;
    else
      brk_cnt <= next_brk_cnt;
  end

  // ----------------------------------------------------------------
  // lanes and normal output control
  // ----------------------------------------------------------------
  logic [LANES-1:0] lane_out;
  logic [LANES-1:0] norm_out;
  logic [LANES-1:0] next_pins;
  logic [LANES-1:0] pins;

  genvar n;
  generate
    for (n = 0; n < LANES; n++)
    begin : g_lane
      // entry zero drives the pwm pin with the faster limit
      dor_output_lane #(
        .GAP((n == 0) ? PWM_GAP : OUT_GAP)
      ) u_dor_output_lane (
        .hclk(hclk),
        .hresetn(hresetn),
        .route(route[n]),
        .out_word(digital_output_word),
        .enc_tick(enc_tick),
        .pos_tick(pos_tick),
        .brake_pwm(brake_pwm),
        .lane_out(lane_out[n])
      );
      // normal mode: lane n (output n-1) sits at word bit 15+n, pwm lane at bit 0
      localparam int WB = (n == 0) ? 0 : 15 + n;
      assign norm_out[n] = man_sel[WB] ? man_val[WB]
                                       : digital_output_word[WB] ^ polarity[WB];
    end
  endgenerate

  // routing replaces the normal path and its polarity and manual control
  always_comb
  begin
    next_pins = route_en ? lane_out : norm_out;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pins <= '0;
    else
      pins <= next_pins;
  end

  assign pwm_out = pins[0];
  assign dig_out = pins[LANES-1:1];
  assign pin_state = 32'(pins);
endmodule

// File: testbench/dor_checker.sv
// Purpose: bus and pin timing properties of the router
// Assumes: zero-wait slave, registered pins
// Notes: only bit 0 of dig_out (lane 1) is rate checked
module dor_checker #(
  parameter int NUM_OUT = 2,
  parameter int PWM_GAP = 4,
  parameter int OUT_GAP = 8
) (
  // bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  // counts and pins
  input wire logic [31:0] enc_count,
  input wire logic pwm_out,
  input wire logic [NUM_OUT-1:0] dig_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import dor_pkg::*;
  // ----
  // helpers
  // ----
  logic rd;
  logic pq;
  logic oq;
  int pc;
  int oc;
  assign rd = hsel && hready && htrans[1] && !hwrite;
  // cycles since each pin moved, saturated so it never wraps
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pq <= 1'b0;
      oq <= 1'b0;
      pc <= 999;
      oc <= 999;
    end
    else
    begin
      pq <= pwm_out;
      oq <= dig_out[0];
      pc <= (pwm_out != pq) ? 0 : pc + int'(pc < 999);
      oc <= (dig_out[0] != oq) ? 0 : oc + int'(oc < 999);
    end
  end
  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ----
  // properties
  // ----
  okay_resp_a: assert property (hresp == 1'b0) else $error("bad resp");
  idle_rdata_a: assert property (!rd |=> hrdata == 32'h0) else $error("rdata not 0");
  enc_read_a: assert property (rd && haddr[7:0] == DOR_OFS_ENC_CNT |=>
    hrdata == $past(enc_count)) else $error("count read");
  hole_read_a: assert property (rd && haddr[7:0] == 8'h30 |=> hrdata == 32'h0)
    else $error("hole read");
  route_width_a: assert property (rd && haddr[7:4] == 4'h4 |=> hrdata[31:16] == 16'h0)
    else $error("route width");
  pin_read_a: assert property (rd && haddr[7:0] == DOR_OFS_PIN_STATE |=>
    hrdata[0] == $past(pwm_out) && hrdata[NUM_OUT:1] == $past(dig_out))
    else $error("pin read");
  pwm_gap_a: assert property (pwm_out != pq |-> pc >= PWM_GAP - 1)
    else $error("pwm too fast");
  out_gap_a: assert property (dig_out[0] != oq |-> oc >= OUT_GAP - 1)
    else $error("out too fast");
  cover property (rd && haddr[7:0] == DOR_OFS_PIN_STATE);
  cover property (pwm_out != pq);
  cover property (dig_out[0] != oq);
endmodule

bind dor_top dor_checker #(.NUM_OUT(NUM_OUT), .PWM_GAP(PWM_GAP), .OUT_GAP(OUT_GAP)) u_dor_checker (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hresp(hresp),
  .enc_count(enc_count), .pwm_out(pwm_out), .dig_out(dig_out));

// File: testbench/dor_load_model.sv
// Purpose: loads on the routed output pins
// Assumes: pins settle within one hclk
// Notes: a load sees level changes only, so each is counted
module dor_load_model (
  // clock and pins
  input wire logic hclk,
  input wire logic pwm_pin,
  input wire logic out_pin,
  // change counts
  output int pwm_edges,
  output int out_edges
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pwm_q = 1'b0;
  logic out_q = 1'b0;
  // count every level change seen at the load
  always @(posedge hclk)
  begin
    pwm_edges <= pwm_edges + int'(pwm_pin != pwm_q);
    out_edges <= out_edges + int'(out_pin != out_q);
    pwm_q <= pwm_pin;
    out_q <= out_pin;
  end
endmodule

// File: testbench/tb_digital_output_routing.sv
// Purpose: self-checking bench for the output router
// Assumes: zero-wait slave, gaps shortened to 4 and 8
// Notes: pin levels are read back via the pin state word
module tb_digital_output_routing;
  timeunit 1ns;
  timeprecision 1ps;
  import dor_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] enc_count = 32'h0;
  logic [31:0] pos_count = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic pwm_out;
  logic [1:0] dig_out;
  int pe;
  int oe;
  int err_count = 0;
  int n_checks = 0;
  int seed = 33;
  logic rdp = 1'b0;
  logic [63:0] q[$];
  logic [63:0] e;
  always #10 hclk = ~hclk;
  dor_top #(.NUM_OUT(2), .PWM_GAP(4), .OUT_GAP(8)) u_dor_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .enc_count(enc_count),
    .pos_count(pos_count), .pwm_out(pwm_out), .dig_out(dig_out));
  dor_load_model u_dor_load_model (.hclk(hclk), .pwm_pin(pwm_out),
    .out_pin(dig_out[0]), .pwm_edges(pe), .out_edges(oe));
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x)
    begin
      err_count++;
      $display("[ERR] %0t saw %h want %h", $time, s, x);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // wait for hready at an edge, bounded
  task automatic wt();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
    begin
      err_count++;
      $display("[ERR] %0t bus hang", $time);
      report_and_stop();
    end
  endtask
  // one single-word transfer; the leading edge keeps drives apart
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wt();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wt();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = '1);
    q.push_back({m, x});
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic near(input int g, input int x, input int t);
    chk({31'h0, (g - x) * (g - x) <= t * t}, 32'h1);
  endtask
  // read data are judged in the data phase against the oldest note
  always @(posedge hclk)
  begin
    if (rdp && hreadyout === 1'b1 && q.size() > 0)
    begin
      e = q.pop_front();
      chk(hrdata & e[63:32], e[31:0]);
    end
    rdp <= hsel && htrans[1] && !hwrite && hreadyout;
  end
  initial
  begin
    int i;
    int c;
    int o0;
    logic [4:0] idx;
    logic [31:0] w;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd(DOR_OFS_ROUTE0, {16'h0, DOR_ROUTE_RST});
    rd(DOR_OFS_BRAKE_PER, {16'h0, DOR_BRAKE_PER_RST});
    rd(DOR_OFS_BRAKE_ON, {16'h0, DOR_BRAKE_ON_RST});
    rd(DOR_OFS_ROUTE_EN, 32'h0);
    rd(8'h30, 32'h0);
    $display("reset test done");
    // enable value other than one keeps normal output control
    wr(DOR_OFS_OUT_WORD, 32'h0001_0001);
    wr(DOR_OFS_ROUTE_EN, 32'h2);
    repeat (20) @(posedge hclk);
    rd(DOR_OFS_PIN_STATE, 32'h3, 32'h7);
    // polarity, then manual control, act on the pins while routing is off
    wr(DOR_OFS_POLARITY, 32'hffffffff);
    rd(DOR_OFS_PIN_STATE, 32'h4, 32'h7);
    wr(DOR_OFS_MAN_VAL, 32'h0001_0000);
    wr(DOR_OFS_MAN_SEL, 32'hffffffff);
    repeat (20) @(posedge hclk);
    rd(DOR_OFS_PIN_STATE, 32'h2, 32'h7);
    $display("normal test done");
    // overrides left set must have no effect while routing; the pins jump
    // once here, so the toggle gap is waited out before routes move
    wr(DOR_OFS_ROUTE_EN, 32'h1);
    repeat (20) @(posedge hclk);
    for (i = 0; i < 6; i++)
    begin
      idx = 5'($random(seed));
      w = $random(seed);
      wr(DOR_OFS_ROUTE0, {16'h0, DOR_SRC_ONE, 3'h0, idx});
      wr(DOR_OFS_ROUTE0 + DOR_ROUTE_STRIDE, {16'h0, DOR_SRC_ONE, 3'h4, idx});
      wr(DOR_OFS_ROUTE0 + 8'h8, {16'h0, i[0] ? DOR_SRC_ZERO : 8'h20, 3'h0, idx});
      wr(DOR_OFS_OUT_WORD, w);
      repeat (20) @(posedge hclk);
      rd(DOR_OFS_PIN_STATE, {30'h0, !w[idx], w[idx]}, 32'h7);
    end
    $display("gate test done");
    // brake pwm and its inverse, gated by word bit 0
    wr(DOR_OFS_ROUTE0, {16'h0, DOR_SRC_BRK, 8'h00});
    wr(DOR_OFS_ROUTE0 + DOR_ROUTE_STRIDE, {16'h0, DOR_SRC_BRK_N, 8'h00});
    wr(DOR_OFS_OUT_WORD, 32'h0001_0001);
    c = pe;
    o0 = oe;
    repeat (2000) @(posedge hclk);
    near(pe - c, 4000 / int'(DOR_BRAKE_PER_RST), 2);
    near(oe - o0, 4000 / int'(DOR_BRAKE_PER_RST), 2);
    // a shorter period and duty: 40 cycles, 20 high, so 100 edges
    wr(DOR_OFS_BRAKE_PER, 32'h0000_0028);
    wr(DOR_OFS_BRAKE_ON, 32'h0000_0014);
    c = pe;
    o0 = oe;
    repeat (2000) @(posedge hclk);
    near(pe - c, 100, 2);
    near(oe - o0, 100, 2);
    $display("brake test done");
    // 64 unit steps per source, spaced wider than the toggle gap
    for (c = 2; c < 16; c++)
    begin
      wr(DOR_OFS_ROUTE0 + DOR_ROUTE_STRIDE, {16'h0, 8'(c), 8'h10});
      repeat (20) @(posedge hclk);
      o0 = oe;
      for (i = 0; i < 64; i++)
      begin
        @(posedge hclk);
        enc_count <= enc_count + 32'(c < 9);
        pos_count <= pos_count + 32'(c >= 9);
        repeat (12) @(posedge hclk);
      end
      near(oe - o0, 64 >> ((c - 2) % 7), 1);
    end
    rd(DOR_OFS_ENC_CNT, enc_count);
    // let the watcher judge the last read before the verdict
    repeat (2) @(posedge hclk);
    $display("pulse test done");
    report_and_stop();
  end
endmodule
